// [core/psram_latency_refresh_config.sv]
// Purpose: latency, refresh and deep power-down control of the array
// Assumes: bus front-end decodes transactions on mclk_i
// Notes: select pin is synchronised here; all outputs registered
`timescale 1ns/1ps
module psram_latency_refresh_config #(
    parameter int WAKE_CYC = psram_cfg_pkg::DPD_OUT_CYC,
    parameter int ENTER_CYC = psram_cfg_pkg::DPD_IN_CYC,
    parameter int REFI_CYC = psram_cfg_pkg::REFI_BASE_CYC,
    parameter int REF_BUSY_CYC = 8
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic cs_n_i,
    input wire psram_cfg_pkg::txn_s txn_i,
    input wire logic [psram_cfg_pkg::ROW_W-1:0] row_i,
    input wire logic reg_wr_i,
    input wire logic reg_sel_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    output logic strobe_o,
    output logic strobe_oe_o,
    output logic [4:0] lat_clocks_o,
    output logic lat_valid_o,
    output logic [2:0] drive_o,
    output psram_cfg_pkg::array_cmd_s array_cmd_o,
    output logic array_valid_o,
    output logic power_down_o,
    output logic ready_o
);
    // timer width covers both power-down waits
    localparam int TW = $clog2(WAKE_CYC + ENTER_CYC + 2);
    localparam int RW = $clog2(4 * REFI_CYC + 1);
    localparam int BW = $clog2(REF_BUSY_CYC + 1);

    // refuse settings the counters cannot serve
    if (WAKE_CYC < 1 || ENTER_CYC < 1 || REFI_CYC < 2 ||
        REF_BUSY_CYC < 1) begin : g_bad
        $error("timing parameters must be at least one cycle");
    end

    // select pin synchroniser
    logic cs_m_q, cs_s_q, cs_p_q;
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            cs_m_q <= 1'b1;
            cs_s_q <= 1'b1;
            cs_p_q <= 1'b1;
        end else begin
            cs_m_q <= cs_n_i;
            cs_s_q <= cs_m_q;
            cs_p_q <= cs_s_q;
        end
    end
    // rising edge of the synchronised select
    logic cs_rise;
    assign cs_rise = cs_s_q && !cs_p_q;

    // ---------------- configuration and power state ----------------
    logic [15:0] lat_cfg_q, lat_cfg_d;   // latency/drive/power config
    logic [15:0] ref_cfg_q, ref_cfg_d;   // refresh interval config
    psram_cfg_pkg::pwr_e pwr_q, pwr_d;   // power state
    logic [TW-1:0] ptim_q, ptim_d;       // power-down timer
    logic seen_low_q, seen_low_d;        // select went low in power-down
    logic valid_q, valid_d;              // array contents valid

    // next config, power state and wake handling
    always_comb begin
        lat_cfg_d = lat_cfg_q;
        ref_cfg_d = ref_cfg_q;
        pwr_d = pwr_q;
        ptim_d = ptim_q;
        seen_low_d = seen_low_q;
        valid_d = valid_q;
        case (pwr_q)
            psram_cfg_pkg::PWR_ON: begin
                // host write gives the array defined contents
                if (txn_i.start && !txn_i.reg_sp && !txn_i.read) begin
                    valid_d = 1'b1;
                end
                // register capture never waits on refresh
                if (reg_wr_i && reg_sel_i == psram_cfg_pkg::SEL_LAT_CFG)
                begin
                    lat_cfg_d = reg_wdata_i & psram_cfg_pkg::LAT_CFG_MASK;
                    // clearing the power bit starts entry
                    if (!reg_wdata_i[psram_cfg_pkg::PWR_BIT]) begin
                        pwr_d = psram_cfg_pkg::PWR_ENTER;
                        ptim_d = TW'(ENTER_CYC - 1);
                        valid_d = 1'b0;
                    end
                end else if (reg_wr_i) begin
                    // reserved bits kept at zero
                    ref_cfg_d = reg_wdata_i & psram_cfg_pkg::REF_CFG_MASK;
                end
            end
            psram_cfg_pkg::PWR_ENTER: begin
                // wait out the entry time, then sleep
                if (ptim_q == '0) begin
                    pwr_d = psram_cfg_pkg::PWR_DOWN;
                    seen_low_d = 1'b0;
                end else begin
                    ptim_d = ptim_q - TW'(1);
                end
            end
            psram_cfg_pkg::PWR_DOWN: begin
                // only the select pin is watched
                if (!cs_s_q) begin
                    seen_low_d = 1'b1;
                end
                if (seen_low_q && cs_rise) begin
                    pwr_d = psram_cfg_pkg::PWR_WAKE;
                    ptim_d = TW'(WAKE_CYC - 1);
                end
            end
            psram_cfg_pkg::PWR_WAKE: begin
                // wake time, then back to reset defaults
                if (ptim_q == '0) begin
                    pwr_d = psram_cfg_pkg::PWR_ON;
                    lat_cfg_d = psram_cfg_pkg::LAT_CFG_RST;
                    ref_cfg_d = psram_cfg_pkg::REF_CFG_RST;
                end else begin
                    ptim_d = ptim_q - TW'(1);
                end
            end
            default: begin
                pwr_d = psram_cfg_pkg::PWR_ON;
            end
        endcase
    end

    // config and power registers
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            lat_cfg_q <= psram_cfg_pkg::LAT_CFG_RST;
            ref_cfg_q <= psram_cfg_pkg::REF_CFG_RST;
            pwr_q <= psram_cfg_pkg::PWR_ON;
            ptim_q <= '0;
            seen_low_q <= 1'b0;
            valid_q <= 1'b0;
        end else begin
            lat_cfg_q <= lat_cfg_d;
            ref_cfg_q <= ref_cfg_d;
            pwr_q <= pwr_d;
            ptim_q <= ptim_d;
            seen_low_q <= seen_low_d;
            valid_q <= valid_d;
        end
    end

    // latency clocks, out-of-range codes clamped
    logic [3:0] lat_code;
    logic [3:0] lat_clk;
    assign lat_code = lat_cfg_q[psram_cfg_pkg::LAT_HI:psram_cfg_pkg::LAT_LO];
    always_comb begin
        if (lat_code < psram_cfg_pkg::LAT_MIN) begin
            lat_clk = psram_cfg_pkg::LAT_MIN;
        end else if (lat_code > psram_cfg_pkg::LAT_MAX) begin
            lat_clk = psram_cfg_pkg::LAT_MAX;
        end else begin
            lat_clk = lat_code;
        end
    end

    // ---------------- distributed self-refresh ----------------
    logic [RW-1:0] rtim_q, rtim_d;       // interval timer
    logic pend_q, pend_d;                // refresh owed
    logic [BW-1:0] busy_q, busy_d;       // refresh in progress count
    logic [psram_cfg_pkg::ROW_W-1:0] row_q, row_d; // next row
    logic act_q, act_d;                  // array access active
    logic [psram_cfg_pkg::ROW_W-1:0] arow_q, arow_d; // accessed row
    psram_cfg_pkg::array_cmd_s cmd_q, cmd_d;
    logic [RW-1:0] interval;

    // interval from the refresh code
    always_comb begin
        case (ref_cfg_q[1:0])
            psram_cfg_pkg::RI_X1: interval = RW'(REFI_CYC);
            psram_cfg_pkg::RI_X15: interval = RW'(REFI_CYC * 3 / 2);
            psram_cfg_pkg::RI_X2: interval = RW'(REFI_CYC * 2);
            psram_cfg_pkg::RI_X4: interval = RW'(REFI_CYC * 4);
            default: interval = RW'(REFI_CYC);
        endcase
    end

    // a transaction accepted while awake
    logic take;
    assign take = txn_i.start && pwr_q == psram_cfg_pkg::PWR_ON;

    // refresh scheduling and array commands
    always_comb begin
        rtim_d = rtim_q;
        pend_d = pend_q;
        busy_d = busy_q;
        row_d = row_q;
        act_d = act_q;
        arow_d = arow_q;
        cmd_d = '0;
        cmd_d.row = cmd_q.row;
        if (pwr_q != psram_cfg_pkg::PWR_ON) begin
            // power-down halts all refresh
            rtim_d = '0;
            pend_d = 1'b0;
            busy_d = '0;
            act_d = 1'b0;
        end else begin
            // register writes leave the array free
            if (take && !(txn_i.reg_sp && !txn_i.read)) begin
                act_d = 1'b1;
                arow_d = row_i;
            end else if (cs_rise && act_q) begin
                // the accessed row is written back
                act_d = 1'b0;
                cmd_d.writeback = 1'b1;
                cmd_d.row = arow_q;
            end
            if (busy_q != '0) begin
                busy_d = busy_q - BW'(1);
            end else if (pend_q && !act_q && !take) begin
                // refresh only between accesses
                pend_d = 1'b0;
                busy_d = BW'(REF_BUSY_CYC);
                cmd_d.refresh = 1'b1;
                cmd_d.row = row_q;
                row_d = row_q + psram_cfg_pkg::ROW_W'(1);
            end
            // one row per interval; a new interval wins over the clear
            if (rtim_q >= interval - RW'(1)) begin
                rtim_d = '0;
                pend_d = 1'b1;
            end else begin
                rtim_d = rtim_q + RW'(1);
            end
        end
    end

    // refresh registers
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            rtim_q <= '0;
            pend_q <= 1'b0;
            busy_q <= '0;
            row_q <= '0;
            act_q <= 1'b0;
            arow_q <= '0;
            cmd_q <= '0;
        end else begin
            rtim_q <= rtim_d;
            pend_q <= pend_d;
            busy_q <= busy_d;
            row_q <= row_d;
            act_q <= act_d;
            arow_q <= arow_d;
            cmd_q <= cmd_d;
        end
    end

    // ---------------- latency answer and strobe ----------------
    logic strobe_q, strobe_d;
    logic soe_q, soe_d;
    logic [4:0] lat_q, lat_d;
    logic lv_q, lv_d;
    logic [15:0] rd_q, rd_d;
    logic dbl;

    // double latency when forced or refresh owed/running
    assign dbl = lat_cfg_q[psram_cfg_pkg::FIX_BIT] || pend_q ||
                 busy_q != '0;

    // strobe level and latency at command-address
    always_comb begin
        strobe_d = strobe_q;
        soe_d = soe_q;
        lat_d = lat_q;
        lv_d = 1'b0;
        rd_d = rd_q;
        if (take) begin
            soe_d = 1'b1;
            strobe_d = dbl;  // low when neither applies
            lv_d = 1'b1;
            if (txn_i.reg_sp && !txn_i.read) begin
                lat_d = '0;
            end else if (dbl) begin
                lat_d = {lat_clk, 1'b0};
            end else begin
                lat_d = {1'b0, lat_clk};
            end
        end else if (cs_s_q) begin
            // release the strobe line when deselected
            soe_d = 1'b0;
            strobe_d = 1'b0;
        end
        // register read data
        if (reg_rd_i) begin
            rd_d = reg_sel_i ? ref_cfg_q : lat_cfg_q;
        end
    end

    // latency answer registers
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            strobe_q <= 1'b0;
            soe_q <= 1'b0;
            lat_q <= '0;
            lv_q <= 1'b0;
            rd_q <= '0;
        end else begin
            strobe_q <= strobe_d;
            soe_q <= soe_d;
            lat_q <= lat_d;
            lv_q <= lv_d;
            rd_q <= rd_d;
        end
    end

    // power outputs registered apart from state
    logic pd_q, rdy_q;
    logic [2:0] drv_q;
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            pd_q <= 1'b0;
            rdy_q <= 1'b0;
            drv_q <= psram_cfg_pkg::DRV_DEF;
        end else begin
            pd_q <= pwr_d != psram_cfg_pkg::PWR_ON;
            rdy_q <= pwr_d == psram_cfg_pkg::PWR_ON;
            drv_q <= lat_cfg_d[psram_cfg_pkg::DRV_HI:psram_cfg_pkg::DRV_LO];
        end
    end

    // outputs
    assign reg_rdata_o = rd_q;
    assign strobe_o = strobe_q;
    assign strobe_oe_o = soe_q;
    assign lat_clocks_o = lat_q;
    assign lat_valid_o = lv_q;
    assign drive_o = drv_q;
    assign array_cmd_o = cmd_q;
    assign array_valid_o = valid_q;
    assign power_down_o = pd_q;
    assign ready_o = rdy_q;
endmodule : psram_latency_refresh_config

// [core/psram_cfg_pkg.sv]
// Purpose: constants and types of the latency/refresh/power-down block
// Assumes: 200 MHz core clock
// Notes: field positions and timing counts live here, except the refresh code field and the refresh busy count
package psram_cfg_pkg;
    // core clock period
    localparam int CLK_PS = 5000;
    // register selector values
    localparam logic SEL_LAT_CFG = 1'b0;
    localparam logic SEL_REF_CFG = 1'b1;
    // latency/drive/power config fields
    localparam int PWR_BIT = 15;
    localparam int DRV_HI = 14;
    localparam int DRV_LO = 12;
    localparam int LAT_HI = 7;
    localparam int LAT_LO = 4;
    localparam int FIX_BIT = 3;
    localparam logic [3:0] LAT_MIN = 4'h3;
    localparam logic [3:0] LAT_MAX = 4'h8;
    localparam logic [3:0] LAT_DEF = 4'h6;
    localparam logic [2:0] DRV_DEF = 3'h0;
    // writable bits and reset values of the two config registers
    localparam logic [15:0] LAT_CFG_MASK = 16'hF0F8;
    localparam logic [15:0] LAT_CFG_RST = 16'h8068;
    localparam logic [15:0] REF_CFG_MASK = 16'h0003;
    localparam logic [15:0] REF_CFG_RST = 16'h0002;
    // refresh interval codes
    localparam logic [1:0] RI_X2 = 2'h0;
    localparam logic [1:0] RI_X4 = 2'h1;
    localparam logic [1:0] RI_X1 = 2'h2;
    localparam logic [1:0] RI_X15 = 2'h3;
    // array geometry and refresh timing
    localparam int ROWS = 8192;
    localparam int ROW_W = 13;
    localparam int REFI_BASE_NS = 4000;
    localparam int REFI_BASE_CYC = REFI_BASE_NS * 1000 / CLK_PS;
    // power-down entry (least) and wake (longest) times
    localparam int DPD_IN_NS = 10000;
    localparam int DPD_IN_CYC = (DPD_IN_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int DPD_OUT_NS = 150000;
    localparam int DPD_OUT_CYC = DPD_OUT_NS * 1000 / CLK_PS;
    // transaction descriptor from the bus front-end
    typedef struct packed {
        logic start;   // one-cycle pulse at command-address
        logic reg_sp;  // register space
        logic read;    // read transaction
    } txn_s;
    // command to the array
    typedef struct packed {
        logic refresh;           // refresh one row
        logic writeback;         // write row buffer back
        logic [ROW_W-1:0] row;   // row address
    } array_cmd_s;
    // power states
    typedef enum logic [1:0] {
        PWR_ON, PWR_ENTER, PWR_DOWN, PWR_WAKE
    } pwr_e;
endpackage : psram_cfg_pkg

// [verification/psram_lrc_properties.sv]
// Purpose: concurrent checks on the latency/refresh/power-down block
// Assumes: bound to the block, sees its ports only
// Notes: wake bound allows slack for the select synchroniser
`timescale 1ns/1ps
module psram_lrc_properties #(
    parameter int WAKE_CYC = 20
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic cs_n_i,
    input wire psram_cfg_pkg::txn_s txn_i,
    input wire logic [psram_cfg_pkg::ROW_W-1:0] row_i,
    input wire logic reg_wr_i,
    input wire logic reg_sel_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic strobe_o,
    input wire logic strobe_oe_o,
    input wire logic [4:0] lat_clocks_o,
    input wire logic lat_valid_o,
    input wire logic [2:0] drive_o,
    input wire psram_cfg_pkg::array_cmd_s array_cmd_o,
    input wire logic array_valid_o,
    input wire logic power_down_o,
    input wire logic ready_o
);
    localparam int WAKE_MAX = WAKE_CYC + 6; // sync, count, state reg
    logic fix_q, fix_d; // fixed latency bit as last written
    logic [psram_cfg_pkg::ROW_W-1:0] row_q, row_d; // row of last access
    // next tracked fixed bit and access row
    always_comb begin
        fix_d = fix_q;
        row_d = row_q;
        if (power_down_o) begin
            fix_d = 1'b1; // wake brings defaults back
        end else if (reg_wr_i && !reg_sel_i && ready_o) begin
            fix_d = reg_wdata_i[psram_cfg_pkg::FIX_BIT];
        end
        if (txn_i.start && ready_o) begin
            row_d = row_i;
        end
    end
    // register tracked state
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            fix_q <= 1'b1;
            row_q <= '0;
        end else begin
            fix_q <= fix_d;
            row_q <= row_d;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    // select pulse while power_down_o is high (entry, sleep or wake)
    sequence wake_req;
        power_down_o ##1 (power_down_o && $rose(cs_n_i));
    endsequence
    sequence back_on;
        ##[1:WAKE_MAX] ready_o;
    endsequence
    lat_answer_a: assert property (
        txn_i.start && ready_o |=> lat_valid_o && strobe_oe_o)
        else $error("latency answer missing");
    fixed_strobe_a: assert property (
        lat_valid_o && fix_q && $past(!txn_i.reg_sp || txn_i.read)
        |-> strobe_o && !lat_clocks_o[0] && lat_clocks_o inside {[6:16]})
        else $error("fixed latency not doubled");
    single_lat_a: assert property (
        lat_valid_o && !strobe_o && $past(!txn_i.reg_sp || txn_i.read)
        |-> lat_clocks_o inside {[3:8]})
        else $error("single latency out of range");
    regwr_zero_a: assert property (
        $past(txn_i.start && ready_o && txn_i.reg_sp && !txn_i.read)
        |-> lat_valid_o && lat_clocks_o == 5'h0)
        else $error("register write latency not zero");
    pd_entry_a: assert property (
        reg_wr_i && !reg_sel_i && ready_o && !reg_wdata_i[15]
        |=> power_down_o && !ready_o && !array_valid_o)
        else $error("power-down not entered");
    pd_no_refresh_a: assert property (
        power_down_o && $past(power_down_o) |-> !array_cmd_o.refresh)
        else $error("refresh during power-down");
    wake_time_a: assert property (wake_req |-> back_on)
        else $error("wake took too long");
    defer_refresh_a: assert property (
        txn_i.start && ready_o && !(txn_i.reg_sp && !txn_i.read)
        |=> (!array_cmd_o.refresh || $past(cs_n_i)) [*8])
        else $error("refresh during host access");
    writeback_row_a: assert property (
        array_cmd_o.writeback |-> array_cmd_o.row == row_q && $past(cs_n_i))
        else $error("writeback row wrong");
    drive_code_a: assert property (
        reg_wr_i && !reg_sel_i && ready_o
        |=> drive_o == $past(reg_wdata_i[14:12]))
        else $error("drive code not taken");
    refresh_gap_a: assert property (
        array_cmd_o.refresh |=> !array_cmd_o.refresh [*7])
        else $error("refreshes too close");
endmodule : psram_lrc_properties
bind psram_latency_refresh_config psram_lrc_properties #(
    .WAKE_CYC(WAKE_CYC)
) props (
    .mclk_i(mclk_i), .reset_i(reset_i), .cs_n_i(cs_n_i), .txn_i(txn_i),
    .row_i(row_i), .reg_wr_i(reg_wr_i), .reg_sel_i(reg_sel_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .strobe_o(strobe_o),
    .strobe_oe_o(strobe_oe_o), .lat_clocks_o(lat_clocks_o),
    .lat_valid_o(lat_valid_o), .drive_o(drive_o),
    .array_cmd_o(array_cmd_o), .array_valid_o(array_valid_o),
    .power_down_o(power_down_o), .ready_o(ready_o)
);

// [verification/psram_host_model.sv]
// Purpose: host memory controller driving select, transactions, registers
// Assumes: inputs change 1 ns after the rising edge
// Notes: released selector, descriptor, row and data lines show the inverse of their last value; strobes return low
`timescale 1ns/1ps
module psram_host_model (
    input wire logic mclk_i,
    output logic cs_n_o,
    output psram_cfg_pkg::txn_s txn_o,
    output logic [psram_cfg_pkg::ROW_W-1:0] row_o,
    output logic reg_wr_o,
    output logic reg_sel_o,
    output logic [15:0] reg_wdata_o,
    output logic reg_rd_o
);
    // idle bus at time zero
    initial begin
        cs_n_o = 1'b1;
        txn_o = '0;
        row_o = '0;
        reg_wr_o = 1'b0;
        reg_sel_o = 1'b0;
        reg_wdata_o = '0;
        reg_rd_o = 1'b0;
    end
    // step just past the next rising edge
    task automatic step();
        @(posedge mclk_i);
        #1;
    endtask : step
    // one register write; callers keep reserved bits zero
    task automatic wr(input logic sel, input logic [15:0] d);
        step();
        reg_wr_o = 1'b1;
        reg_sel_o = sel;
        reg_wdata_o = d;
        step();
        reg_wr_o = 1'b0;
        reg_sel_o = ~sel;
        reg_wdata_o = ~d;
    endtask : wr
    // one register read request
    task automatic rd(input logic sel);
        step();
        reg_rd_o = 1'b1;
        reg_sel_o = sel;
        step();
        reg_rd_o = 1'b0;
        reg_sel_o = ~sel;
    endtask : rd
    // select low, command-address, bounded low time, release
    task automatic txn(input logic rs, input logic rdn,
                       input logic [psram_cfg_pkg::ROW_W-1:0] row,
                       input int hold);
        step();
        cs_n_o = 1'b0;
        repeat (2) step();
        txn_o = '{start: 1'b1, reg_sp: rs, read: rdn};
        row_o = row;
        step();
        txn_o = '{start: 1'b0, reg_sp: ~rs, read: ~rdn};
        row_o = ~row;
        repeat (hold) step();
        cs_n_o = 1'b1;
        repeat (4) step();
    endtask : txn
    // catch-up refresh: short reads of sequential rows
    task automatic catch_up(input logic [psram_cfg_pkg::ROW_W-1:0] first,
                            input int cnt);
        for (int i = 0; i < cnt; i++) begin
            txn(1'b0, 1'b1, first + psram_cfg_pkg::ROW_W'(i), 2);
        end
    endtask : catch_up
endmodule : psram_host_model

// [verification/psram_latency_refresh_config_test.sv]
// Purpose: self-checking bench of the latency/refresh/power-down block
// Assumes: shortened counts set by parameters below
// Notes: notes queued by the driver, compared by the monitor
`timescale 1ns/1ps
module psram_latency_refresh_config_test;
    localparam int REFI = 16; // shortened refresh base interval
    localparam int ENTER = 10; // shortened power-down entry
    logic mclk_i, reset_i, cs_n, reg_wr, reg_sel, reg_rd;
    logic strobe_o, strobe_oe_o, lat_valid_o, array_valid_o;
    logic power_down_o, ready_o, rd_pend, acc;
    psram_cfg_pkg::txn_s txn;
    psram_cfg_pkg::array_cmd_s array_cmd_o;
    logic [12:0] row;
    logic [15:0] reg_wdata, reg_rdata_o, ex, d;
    logic [4:0] lat_clocks_o;
    logic [2:0] drive_o, drv;
    logic [15:0] lat_q[$], rd_q[$]; // expected latency and read notes
    int miscompares = 0, tests_run = 0, seed = 26, n, l, ref_in_acc = 0;
    int iv[4] = '{2 * REFI, 4 * REFI, REFI, REFI * 3 / 2};
    psram_host_model host (.mclk_i(mclk_i), .cs_n_o(cs_n), .txn_o(txn),
        .row_o(row), .reg_wr_o(reg_wr), .reg_sel_o(reg_sel),
        .reg_wdata_o(reg_wdata), .reg_rd_o(reg_rd));
    psram_latency_refresh_config #(.WAKE_CYC(20), .ENTER_CYC(ENTER),
        .REFI_CYC(REFI), .REF_BUSY_CYC(8)) dut (.mclk_i(mclk_i),
        .reset_i(reset_i), .cs_n_i(cs_n), .txn_i(txn), .row_i(row),
        .reg_wr_i(reg_wr), .reg_sel_i(reg_sel), .reg_wdata_i(reg_wdata),
        .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata_o), .strobe_o(strobe_o),
        .strobe_oe_o(strobe_oe_o), .lat_clocks_o(lat_clocks_o),
        .lat_valid_o(lat_valid_o), .drive_o(drive_o),
        .array_cmd_o(array_cmd_o), .array_valid_o(array_valid_o),
        .power_down_o(power_down_o), .ready_o(ready_o));
    // compare one value
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // verdict and end of run
    task automatic stop_test();
        $display("compares %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    // bounded wait for a condition, failing the run on expiry
    task automatic wait_for(input bit rf, input int lim, output int k);
        k = 0;
        do begin
            @(posedge mclk_i);
            #1;
            k++;
        end while ((rf ? array_cmd_o.refresh : ready_o) !== 1'b1 && k < lim);
        if (k >= lim) begin
            miscompares++;
            stop_test();
        end
    endtask : wait_for
    // note a read and issue it
    task automatic rdchk(input logic sel, input logic [15:0] e);
        rd_q.push_back(e);
        host.rd(sel);
    endtask : rdchk
    // note an expected latency answer and run the access
    task automatic lat(input logic s, input logic [4:0] c, input logic rs,
                       input logic rdn, input int hold);
        lat_q.push_back({10'h0, s, c});
        host.txn(rs, rdn, 13'($random(seed)), hold);
    endtask : lat
    // clock
    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end
    // monitor: compare answers, watch refreshes inside accesses
    always @(posedge mclk_i) begin
        if (rd_pend) chk(reg_rdata_o, rd_q.pop_front());
        rd_pend = (reg_rd === 1'b1);
        if (lat_valid_o === 1'b1) begin
            ex = (lat_q.size() > 0) ? lat_q.pop_front() : 16'hFFFF;
            chk({10'h0, strobe_o, lat_clocks_o}, ex);
        end
        if (acc && array_cmd_o.refresh === 1'b1) ref_in_acc++;
        if (cs_n === 1'b1) acc = 1'b0;
        else if (txn.start === 1'b1 && ready_o === 1'b1 &&
                 !(txn.reg_sp === 1'b1 && txn.read === 1'b0)) acc = 1'b1;
    end
    // watchdog
    initial begin
        repeat (60000) @(posedge mclk_i);
        miscompares++;
        stop_test();
    end
    // main sequence
    initial begin
        reset_i = 1'b1;
        rd_pend = 1'b0;
        acc = 1'b0;
        repeat (8) @(posedge mclk_i);
        #1 reset_i = 1'b0;
        chk({13'h0, drive_o}, 16'h0000);
        rdchk(1'b0, 16'h8068);
        rdchk(1'b1, 16'h0002);
        lat(1'b1, 5'h0C, 1'b0, 1'b1, 10);
        $display("defaults done");
        for (int c = 0; c < 16; c++) begin
            drv = 3'($random(seed));
            d = 16'h8008 | ({13'h0, drv} << 12) | (16'(c) << 4);
            host.wr(1'b0, d);
            chk({13'h0, drive_o}, {13'h0, drv});
            rdchk(1'b0, d & psram_cfg_pkg::LAT_CFG_MASK);
            l = (c < 3) ? 3 : (c > 8) ? 8 : c;
            lat(1'b1, 5'(2 * l), 1'(c), 1'b1, 10);
        end
        $display("latency codes done");
        for (int i = 0; i < 4; i++) begin
            wait_for(1'b1, 200, n);
            host.wr(1'b1, 16'(i));
            rdchk(1'b1, 16'(i));
            wait_for(1'b1, 200, n);
            wait_for(1'b1, 200, n);
            chk(16'(n), 16'(iv[i]));
        end
        $display("refresh interval done");
        host.wr(1'b0, 16'h8040);
        host.wr(1'b1, 16'h0001);
        wait_for(1'b1, 200, n);
        lat(1'b1, 5'h08, 1'b0, 1'b0, 10);
        chk({15'h0, array_valid_o}, 16'h0001);
        wait_for(1'b1, 200, n);
        repeat (12) host.step();
        lat(1'b0, 5'h04, 1'b0, 1'b1, 10);
        lat(1'b0, 5'h04, 1'b1, 1'b1, 10);
        lat(1'b0, 5'h00, 1'b1, 1'b0, 4);
        wait_for(1'b1, 200, n);
        repeat (12) host.step();
        lat(1'b0, 5'h04, 1'b0, 1'b1, 120);
        chk(16'(ref_in_acc), 16'h0000);
        $display("variable latency done");
        host.wr(1'b0, 16'h0048);
        chk({14'h0, power_down_o, array_valid_o}, 16'h0002);
        repeat (ENTER + 5) host.step();
        host.txn(1'b0, 1'b1, 13'h0, 40);
        wait_for(1'b0, 60, n);
        rdchk(1'b0, 16'h8068);
        $display("power-down done");
        host.wr(1'b0, 16'h8030);
        reset_i = 1'b1;
        repeat (3) host.step();
        reset_i = 1'b0;
        rdchk(1'b0, 16'h8068);
        repeat (2) lat_q.push_back(16'h002C);
        host.catch_up(13'h0010, 2);
        repeat (5) host.step();
        chk(16'(lat_q.size() + rd_q.size()), 16'h0000);
        $display("second reset done");
        stop_test();
    end
endmodule : psram_latency_refresh_config_test
